// ---- core/hbridge_pkg.sv ----
// Package: timing constants, state enum and carrier structs of the bridge control
`default_nettype none
package hbridge_pkg;

	// ****************************************
	// Timebase
	// ****************************************
	localparam int unsigned CLK_HZ = 20000000;
	// Coast interval before sleep, in microseconds
	localparam int unsigned SLEEP_ENTRY_TIME_US = 1000;
	localparam int unsigned SLEEP_CYCLES = SLEEP_ENTRY_TIME_US * (CLK_HZ / 1000000);

	// Interval defaults in cycles (no figures printed, plain defaults)
	localparam int unsigned OFF_CYCLES     = 400;
	localparam int unsigned BLANK_CYCLES   = 40;
	localparam int unsigned DEGLITCH_CYCLES = 20;
	localparam int unsigned OCP_DEG_CYCLES = 20;
	localparam int unsigned RETRY_CYCLES   = 4000;
	localparam int unsigned WAKE_CYCLES    = 100;
	localparam int unsigned DEAD_CYCLES    = 4;

	// Counter width used by all interval counters
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_SLEEP,
		ST_WAKE,
		ST_ACTIVE,
		ST_OCP_OFF,
		ST_THERMAL
	} mode_t;

	// Requested drive of one half-bridge
	typedef enum logic [1:0] {
		HB_OFF,
		HB_HIGH,
		HB_LOW
	} half_t;

	// Gate commands of one half-bridge
	typedef struct packed {
		logic hs;
		logic ls;
	} gate_t;

	// Synchronised fault and comparator inputs
	typedef struct packed {
		logic trip;
		logic overcurrent_protect;
		logic thermal;
	} sense_t;

endpackage
`default_nettype wire

// ---- core/half_bridge_dead.sv ----
// One half-bridge driver with dead interval between high and low drive
`default_nettype none
module half_bridge_dead
	import hbridge_pkg::*;
#(
	parameter int unsigned DEAD = DEAD_CYCLES
) (
	input  wire logic  clk_i,
	input  wire logic  nrst_i,
	input  wire half_t req_i,
	output var  gate_t gate_o,
	output var  logic  switching_o
);

	typedef struct packed {
		half_t            cur;
		logic [CNT_W-1:0] dead;
		gate_t            gate;
		logic             sw;
	} hb_state_t;

	hb_state_t st;
	hb_state_t next_st;

	// A change of polarity first passes through both switches off
	always_comb begin
		next_st = st;
		next_st.sw = 1'b0;
		if (st.dead != CNT_ZERO) begin
			next_st.dead = st.dead - 16'h0001;
		end else if (req_i != st.cur) begin
			next_st.sw = 1'b1;
			if ((st.cur == HB_HIGH && req_i == HB_LOW) ||
				(st.cur == HB_LOW && req_i == HB_HIGH)) begin
				next_st.cur  = HB_OFF;
				next_st.dead = CNT_W'(DEAD);
			end else begin
				next_st.cur = req_i;
			end
		end
		next_st.gate.hs = (next_st.cur == HB_HIGH);
		next_st.gate.ls = (next_st.cur == HB_LOW);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '{cur: HB_OFF, dead: CNT_ZERO, gate: 2'b00, sw: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign gate_o      = st.gate;
	assign switching_o = st.sw;

	// Never both switches of one leg on
	AST_NO_SHOOT: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		!(gate_o.hs && gate_o.ls)) else $error("shoot-through");

	// High to low passes an off interval first
	AST_DEAD_GAP: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		$fell(gate_o.hs) |-> !gate_o.ls) else $error("no dead gap");

endmodule
`default_nettype wire

// ---- core/hbridge_ctrl.sv ----
// H-bridge control: decode, chopping, protection and sleep sequencing
`default_nettype none
module hbridge_ctrl
	import hbridge_pkg::*;
#(
	parameter int unsigned OFF_T   = OFF_CYCLES,
	parameter int unsigned BLANK_T = BLANK_CYCLES,
	parameter int unsigned DEG_T   = DEGLITCH_CYCLES,
	parameter int unsigned OCP_T   = OCP_DEG_CYCLES,
	parameter int unsigned RETRY_T = RETRY_CYCLES,
	parameter int unsigned WAKE_T  = WAKE_CYCLES,
	parameter int unsigned SLEEP_T = SLEEP_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic ctrl_in_a_i,
	input  wire logic ctrl_in_b_i,
	input  wire logic chop_trip_i,
	input  wire logic hs_limit_a_i,
	input  wire logic ls_limit_a_i,
	input  wire logic hs_limit_b_i,
	input  wire logic ls_limit_b_i,
	input  wire logic thermal_shutdown_i,
	input  wire logic supply_undervoltage_lock_i,
	output var  gate_t bridge_out_a_o,
	output var  gate_t bridge_out_b_o,
	output var  logic  sleep_o,
	output var  logic  chopping_o,
	output var  logic  fault_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0]       in_m;     // first synchroniser stage
		logic [1:0]       in_s;     // synchronised inputs
		logic [1:0]       in_prev;
		sense_t           sen_m;
		sense_t           sen;
		mode_t            mode;
		logic [CNT_W-1:0] mode_cnt; // wake, sleep and retry counter
		logic             chop;
		logic [CNT_W-1:0] off_cnt;
		logic [CNT_W-1:0] blank_cnt;
		logic [CNT_W-1:0] deg_cnt;
		logic [CNT_W-1:0] ocp_cnt;
		logic             pwr_seen; // first cycle after reset done
		logic             sleep;
		logic             fault;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;

	half_t req_a;
	half_t req_b;
	logic  sw_a;
	logic  sw_b;
	logic  any_limit;
	logic  trip_ok;
	logic  core_nrst;

	// ****************************************
	// Combined limit and trip qualifiers
	// ****************************************
	// Supply lockout clears all logic at once; release is as unsynchronised
	// as the reset pin itself, accepted since both come from the same supply
	assign core_nrst = nrst_i & ~supply_undervoltage_lock_i;
	// Per-switch limits are OR'd, independent of the regulation comparator
	assign any_limit = st.sen.overcurrent_protect;
	// Trip is only trusted after blanking and a full deglitch run
	assign trip_ok = (st.blank_cnt == CNT_ZERO) &&
		(st.deg_cnt >= CNT_W'(DEG_T));

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_st = st;
		// Two-stage synchronisers on the direction, trip, limit and thermal pins
		next_st.in_m    = {ctrl_in_b_i, ctrl_in_a_i};
		next_st.in_s    = st.in_m;
		next_st.in_prev = st.in_s;
		next_st.sen_m.trip    = chop_trip_i;
		next_st.sen_m.overcurrent_protect     = hs_limit_a_i | ls_limit_a_i |
			hs_limit_b_i | ls_limit_b_i;
		next_st.sen_m.thermal = thermal_shutdown_i;
		next_st.sen = st.sen_m;
		next_st.pwr_seen = 1'b1;

		// Blanking restarts on every output switching event, and already on
		// an input change, so a held trip cannot rearm before the legs move
		if (sw_a || sw_b || st.in_s != st.in_prev) begin
			next_st.blank_cnt = CNT_W'(BLANK_T);
		end else if (st.blank_cnt != CNT_ZERO) begin
			next_st.blank_cnt = st.blank_cnt - 16'h0001;
		end

		// Deglitch counts consecutive trip assertion outside blanking
		if (!st.sen.trip || st.blank_cnt != CNT_ZERO) begin
			next_st.deg_cnt = CNT_ZERO;
		end else if (st.deg_cnt < CNT_W'(DEG_T)) begin
			next_st.deg_cnt = st.deg_cnt + 16'h0001;
		end

		// Overcurrent persistence counter
		if (!any_limit || st.mode != ST_ACTIVE) begin
			next_st.ocp_cnt = CNT_ZERO;
		end else if (st.ocp_cnt < CNT_W'(OCP_T)) begin
			next_st.ocp_cnt = st.ocp_cnt + 16'h0001;
		end

		// Fixed off-time chopping
		if (st.mode != ST_ACTIVE) begin
			next_st.chop    = 1'b0;
			next_st.off_cnt = CNT_ZERO;
		end else if (st.chop && st.in_s != st.in_prev) begin
			next_st.chop    = 1'b0;
			next_st.off_cnt = CNT_ZERO;
		end else if (st.chop && st.off_cnt != CNT_ZERO) begin
			next_st.off_cnt = st.off_cnt - 16'h0001;
		end else if (st.chop) begin
			// Off-time over: restart if still above threshold
			if (st.sen.trip) begin
				next_st.off_cnt = CNT_W'(OFF_T - 1);
			end else begin
				next_st.chop = 1'b0;
			end
		end else if (trip_ok && st.in_s != 2'b00) begin
			next_st.chop    = 1'b1;
			next_st.off_cnt = CNT_W'(OFF_T - 1);
		end

		// Mode sequencing
		unique case (st.mode)
			ST_SLEEP: begin
				if (st.in_s != 2'b00) begin
					next_st.mode     = ST_WAKE;
					next_st.mode_cnt = CNT_ZERO;
				end
			end
			ST_WAKE: begin
				if (st.in_s == 2'b00) begin
					next_st.mode = ST_SLEEP;
				end else if (st.mode_cnt >= CNT_W'(WAKE_T - 1)) begin
					next_st.mode     = ST_ACTIVE;
					next_st.mode_cnt = CNT_ZERO;
				end else begin
					next_st.mode_cnt = st.mode_cnt + 16'h0001;
				end
			end
			ST_ACTIVE: begin
				if (st.sen.thermal) begin
					next_st.mode = ST_THERMAL;
				end else if (st.ocp_cnt >= CNT_W'(OCP_T)) begin
					next_st.mode     = ST_OCP_OFF;
					next_st.mode_cnt = CNT_ZERO;
				end else if (st.in_s != 2'b00) begin
					next_st.mode_cnt = CNT_ZERO;
				end else if (st.mode_cnt >= CNT_W'(SLEEP_T - 1)) begin
					next_st.mode     = ST_SLEEP;
					next_st.mode_cnt = CNT_ZERO;
				end else begin
					next_st.mode_cnt = st.mode_cnt + 16'h0001;
				end
			end
			ST_OCP_OFF: begin
				if (st.mode_cnt >= CNT_W'(RETRY_T - 1)) begin
					next_st.mode     = ST_ACTIVE;
					next_st.mode_cnt = CNT_ZERO;
				end else begin
					next_st.mode_cnt = st.mode_cnt + 16'h0001;
				end
			end
			ST_THERMAL: begin
				// Hysteresis is in the sensor; its clear is the recovery
				if (!st.sen.thermal) begin
					next_st.mode     = ST_ACTIVE;
					next_st.mode_cnt = CNT_ZERO;
				end
			end
		endcase

		// Power-up with both inputs low: sleep at once
		if (!st.pwr_seen) begin
			next_st.mode = ST_SLEEP;
		end

		next_st.sleep = (next_st.mode == ST_SLEEP) ||
			(next_st.mode == ST_WAKE);
		next_st.fault = (next_st.mode == ST_OCP_OFF) ||
			(next_st.mode == ST_THERMAL);
	end

	// ****************************************
	// Bridge request decode
	// ****************************************
	// Outside active mode both legs float; chopping brakes on the low sides
	always_comb begin
		req_a = HB_OFF;
		req_b = HB_OFF;
		if (st.mode == ST_ACTIVE) begin
			if (st.chop) begin
				req_a = HB_LOW;
				req_b = HB_LOW;
			end else begin
				unique case (st.in_s)
					2'b00: begin
						req_a = HB_OFF;
						req_b = HB_OFF;
					end
					2'b01: begin
						req_a = HB_HIGH;
						req_b = HB_LOW;
					end
					2'b10: begin
						req_a = HB_LOW;
						req_b = HB_HIGH;
					end
					2'b11: begin
						req_a = HB_LOW;
						req_b = HB_LOW;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Half-bridges with dead interval
	// ****************************************
	half_bridge_dead #(
		.DEAD (DEAD_CYCLES)
	) leg_a (
		.clk_i       (clk_i),
		.nrst_i      (core_nrst),
		.req_i       (req_a),
		.gate_o      (bridge_out_a_o),
		.switching_o (sw_a)
	);

	half_bridge_dead #(
		.DEAD (DEAD_CYCLES)
	) leg_b (
		.clk_i       (clk_i),
		.nrst_i      (core_nrst),
		.req_i       (req_b),
		.gate_o      (bridge_out_b_o),
		.switching_o (sw_b)
	);

	// ****************************************
	// State register
	// ****************************************
	// Undervoltage lockout drives the asynchronous reset, so all logic
	// is held cleared while supply is low and restarts on recovery.
	always_ff @(posedge clk_i or negedge core_nrst) begin
		if (!core_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sleep_o    = st.sleep;
	assign chopping_o = st.chop;
	assign fault_o    = st.fault;

	// ****************************************
	// Assertions
	// ****************************************
	// Counts cycles spent in overcurrent off, so the retry bound needs
	// no long delay range
	logic [CNT_W-1:0] retry_seen;

	always_ff @(posedge clk_i or negedge core_nrst) begin
		if (!core_nrst) begin
			retry_seen <= CNT_ZERO;
		end else if (st.mode != ST_OCP_OFF) begin
			retry_seen <= CNT_ZERO;
		end else if (retry_seen != {CNT_W{1'b1}}) begin
			retry_seen <= retry_seen + 16'h0001;
		end
	end

	AST_CHOP_START: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.mode == ST_ACTIVE && !st.chop && trip_ok && st.in_s != 2'b00
		&& !(st.sen.thermal) && st.ocp_cnt < CNT_W'(OCP_T))
		|=> st.chop) else $error("trip did not start chop");
	AST_CHOP_END: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.chop && st.off_cnt == CNT_ZERO && !st.sen.trip &&
		st.in_s == st.in_prev && st.mode == ST_ACTIVE)
		|=> !st.chop) else $error("chop did not end");
	AST_CHOP_AGAIN: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.chop && st.off_cnt == CNT_ZERO && st.sen.trip &&
		st.in_s == st.in_prev && st.mode == ST_ACTIVE)
		|=> st.chop && st.off_cnt == CNT_W'(OFF_T - 1))
		else $error("no new off-time");
	AST_CHOP_ABORT: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.chop && st.in_s != st.in_prev) |=> !st.chop)
		else $error("off-time not abandoned");
	AST_BLANK: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.blank_cnt != CNT_ZERO && !st.chop) |=> !st.chop)
		else $error("chop in blanking");
	// Legs follow one edge behind the mode, so the check looks one later
	AST_OCP_OFF: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.mode == ST_OCP_OFF) |=> !st.chop &&
		bridge_out_a_o == 2'b00 && bridge_out_b_o == 2'b00)
		else $error("bridge on in ocp");
	AST_RETRY: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.mode == ST_OCP_OFF) |-> retry_seen < CNT_W'(RETRY_T))
		else $error("no retry");
	AST_THERMAL: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		(st.mode == ST_ACTIVE && st.sen.thermal)
		|=> st.mode == ST_THERMAL) else $error("thermal ignored");
	AST_WAKE: assert property (@(posedge clk_i)
		disable iff (!core_nrst)
		$rose(st.mode == ST_ACTIVE) && $past(st.mode) == ST_WAKE
		|-> $past(st.in_s) != 2'b00) else $error("bad wake");

endmodule
`default_nettype wire

// ---- testbench/mcu_model.sv ----
// Controller model that drives the two direction inputs
`default_nettype none
module mcu_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] req_i,
	input  wire logic       slow_i,
	output var  logic       ctrl_in_a_o,
	output var  logic       ctrl_in_b_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] wait_cnt;

	initial begin
		ctrl_in_a_o = 1'b0;
		ctrl_in_b_o = 1'b0;
		wait_cnt = 3'h0;
	end

	// ****************************************
	// Pin update
	// ****************************************
	// A slow controller moves its pins three edges late; levels then hold
	always @(posedge clk_i) begin
		if (req_i === {ctrl_in_a_o, ctrl_in_b_o}) begin
			wait_cnt <= 3'h0;
		end else if (!slow_i || wait_cnt == 3'h3) begin
			ctrl_in_a_o <= req_i[1];
			ctrl_in_b_o <= req_i[0];
			wait_cnt <= 3'h0;
		end else begin
			wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/hbridge_ctrl_tb_top.sv ----
// Self-checking bench of the bridge control block
`default_nettype none
module hbridge_ctrl_tb_top;
	import hbridge_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Short intervals keep the run brief; waits derive from them
	localparam int unsigned P_OFF = 8;
	localparam int unsigned P_BLK = 4;
	localparam int unsigned P_RET = 20;
	localparam int unsigned P_SLP = 50;
	localparam logic [3:0] G_OFF = 4'h0;
	localparam logic [3:0] G_FWD = 4'h9;
	localparam logic [3:0] G_REV = 4'h6;
	localparam logic [3:0] G_BRK = 4'h5;
	localparam logic [7:0] HI    = 8'hC8;

	logic       clk = 1'b0;
	logic       sys_nrst = 1'b0;
	logic       uv = 1'b0;
	logic       therm = 1'b0;
	logic       slow = 1'b0;
	logic [1:0] req = 2'h0;
	logic [3:0] lim = 4'h0;
	logic [7:0] sense = 8'h00;
	logic [7:0] vref = 8'h64;
	logic       in_a;
	logic       in_b;
	logic       trip;
	gate_t      out_a;
	gate_t      out_b;
	gate_t      pa = '0;
	gate_t      pb = '0;
	logic       sleep;
	logic       chop;
	logic       fault;
	logic [3:0] gates;
	logic [2:0] st;
	int         error_cnt = 0;
	int         check_count = 0;
	int         cyc = 0;
	int         chop_cnt = 0;

	always #25 clk = ~clk;

	// Regulation comparator: sense voltage against reference
	assign trip = (sense >= vref);
	assign gates = {out_a, out_b};
	assign st = {sleep, chop, fault};

	mcu_model mcu_u (
		.clk_i      (clk),
		.req_i      (req),
		.slow_i     (slow),
		.ctrl_in_a_o(in_a),
		.ctrl_in_b_o(in_b)
	);

	// Undervoltage reaches the logic through its reset, as the block expects
	hbridge_ctrl #(
		.OFF_T(P_OFF), .BLANK_T(P_BLK), .DEG_T(3), .OCP_T(3),
		.RETRY_T(P_RET), .WAKE_T(5), .SLEEP_T(P_SLP)
	) dut_u (
		.clk_i                     (clk),
		.nrst_i                    (sys_nrst & ~uv),
		.ctrl_in_a_i               (in_a),
		.ctrl_in_b_i               (in_b),
		.chop_trip_i               (trip),
		.hs_limit_a_i              (lim[3]),
		.ls_limit_a_i              (lim[2]),
		.hs_limit_b_i              (lim[1]),
		.ls_limit_b_i              (lim[0]),
		.thermal_shutdown_i        (therm),
		.supply_undervoltage_lock_i(uv),
		.bridge_out_a_o            (out_a),
		.bridge_out_b_o            (out_b),
		.sleep_o                   (sleep),
		.chopping_o                (chop),
		.fault_o                   (fault)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bounded waits sample on the falling edge, where outputs are settled
	task wait_gates(input logic [3:0] e, input int n);
		for (int i = 0; i < n && gates !== e; i++) @(negedge clk);
		chk("gates", e, gates);
	endtask

	task wait_st(input logic [2:0] e, input int n);
		for (int i = 0; i < n && st !== e; i++) @(negedge clk);
		chk("status", {1'b0, e}, {1'b0, st});
	endtask

	task set_in(input logic [1:0] v);
		@(posedge clk);
		req <= v;
	endtask

	task set_sense(input logic [7:0] v);
		@(posedge clk);
		sense <= v;
	endtask

	task idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task results;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A leg may never jump between high and low drive in one step
	always @(posedge clk) begin
		if (sys_nrst & ~uv)
			chk("dead_gap", 4'h0, {pa.hs & out_a.ls, pa.ls & out_a.hs,
				pb.hs & out_b.ls, pb.ls & out_b.hs});
		pa <= out_a;
		pb <= out_b;
		if (chop === 1'b1) chop_cnt++;
	end

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			results();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	task t_wake;
		wait_st(3'h4, 10);
		chk("gates", G_OFF, gates);
		set_in(2'h2);
		wait_gates(G_FWD, 30);
		chk("status", 4'h0, {1'b0, st});
		set_in(2'h1);
		wait_gates(G_REV, 30);
		set_in(2'h3);
		wait_gates(G_BRK, 30);
		set_in(2'h2);
		wait_gates(G_FWD, 30);
		$display("wake and decode done");
	endtask

	task t_chop;
		int n;
		int c0;
		set_sense(HI);
		wait_st(3'h2, 20);
		wait_gates(G_BRK, 8);
		idle(P_OFF + 2);
		chk("status", 4'h2, {1'b0, st});
		set_sense(8'h00);
		wait_st(3'h0, P_OFF + 6);
		wait_gates(G_FWD, 10);
		set_sense(HI);
		wait_st(3'h2, 30);
		set_in(2'h1);
		wait_st(3'h0, 6);
		for (n = 0; n < 40 && chop !== 1'b1; n++) @(negedge clk);
		chk("blanked", 4'h1, {3'h0, n >= P_BLK});
		set_sense(8'h00);
		wait_st(3'h0, 20);
		wait_gates(G_REV, 10);
		c0 = chop_cnt;
		set_sense(HI);
		set_sense(8'h00);
		idle(20);
		chk("glitch", 4'h0, 4'(chop_cnt - c0));
		$display("chopping done");
	endtask

	task t_ocp;
		logic [3:0] tbl [4];
		tbl = '{4'h4, 4'h2, 4'h8, 4'h1};
		for (int k = 0; k < 4; k++) begin
			if (k == 2) begin
				set_in(2'h2);
				wait_gates(G_FWD, 20);
			end
			@(posedge clk);
			lim <= tbl[k];
			wait_st(3'h1, 15);
			wait_gates(G_OFF, 3);
			wait_st(3'h0, P_RET + 10);
			wait_st(3'h1, 20);
			@(posedge clk);
			lim <= 4'h0;
			wait_st(3'h0, P_RET + 10);
			wait_gates(k < 2 ? G_REV : G_FWD, 10);
		end
		$display("overcurrent done");
	endtask

	task t_therm;
		@(posedge clk);
		therm <= 1'b1;
		wait_st(3'h1, 10);
		wait_gates(G_OFF, 3);
		idle(30);
		chk("status", 4'h1, {1'b0, st});
		@(posedge clk);
		therm <= 1'b0;
		wait_st(3'h0, 10);
		wait_gates(G_FWD, 10);
		$display("thermal done");
	endtask

	task t_sleep;
		set_in(2'h0);
		wait_gates(G_OFF, 10);
		idle(P_SLP - 15);
		chk("status", 4'h0, {1'b0, st});
		wait_st(3'h4, 30);
		set_in(2'h2);
		@(posedge clk);
		set_in(2'h0);
		idle(15);
		chk("status", 4'h4, {1'b0, st});
		chk("gates", G_OFF, gates);
		slow <= 1'b1;
		set_in(2'h1);
		wait_gates(G_REV, 40);
		$display("sleep done");
	endtask

	task t_supply_undervoltage_lock;
		@(posedge clk);
		uv <= 1'b1;
		idle(2);
		chk("gates", G_OFF, gates);
		chk("status", 4'h0, {1'b0, st});
		@(posedge clk);
		uv <= 1'b0;
		wait_gates(G_REV, 40);
		$display("undervoltage done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		sys_nrst <= 1'b1;
		t_wake();
		t_chop();
		t_ocp();
		t_therm();
		t_sleep();
		t_supply_undervoltage_lock();
		results();
	end
endmodule
`default_nettype wire
